// ===== verilog/fsw_pkg.sv
package fsw_pkg;

  // Clock and pin timing.
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_GLITCH_NS = 5;
  // A strobe must outlast the longest pulse the flash treats as noise.
  localparam int STROBE_MIN_CYC = T_GLITCH_NS / CLK_PERIOD_NS + 1;

  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  // APB register offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_RDATA = 8'h14;
  localparam logic [7:0] OFF_CODE = 8'h18;

  // Control register fields.
  localparam int CTRL_WP_LEVEL = 0;
  localparam int CTRL_VID_REQ = 1;
  localparam int CTRL_ACCEL_REQ = 2;
  localparam int CTRL_ALL_PROT = 3;
  localparam int CTRL_REGION_LOCKED = 4;
  localparam int CTRL_TOP_BOOT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Status register fields.
  localparam int ST_BUSY = 0;
  localparam int ST_SECURED = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_READY = 3;
  localparam int ST_VID = 4;
  localparam int ST_ACCEL = 5;
  localparam int ST_PWR_DONE = 6;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_READ = 4'h1,
    OP_PROG = 4'h2,
    OP_ERASE = 4'h3,
    OP_ENTER = 4'h4,
    OP_EXIT = 4'h5,
    OP_CMD3 = 4'h6,
    OP_PROT = 4'h7,
    OP_UNPROT = 4'h8,
    OP_HWRST = 4'h9
  } fsw_op_t;

  // Flash control and data pins as driven by the host.
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic dq_drv_n;
  } fsw_pins_t;

  localparam fsw_pins_t PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
    addr: '0, dq: '0, dq_drv_n: 1'b1};

  // One bus cycle request.
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fsw_cyc_t;

endpackage

// ===== verilog/fsw_bus_cycle.sv
`timescale 1ns/1ps
module fsw_bus_cycle
  import fsw_pkg::*;
#(
  parameter int SETUP_CYC = 1,
  parameter int HOLD_CYC = 1,
  parameter int RD_WAIT_CYC = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire fsw_cyc_t req_i,
  input wire logic [DATA_W-1:0] dq_i,
  output fsw_pins_t pins_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic done_o
);

  if (SETUP_CYC < 1 || SETUP_CYC > 256 || HOLD_CYC < 1 || HOLD_CYC > 256 ||
      RD_WAIT_CYC < 1 || RD_WAIT_CYC > 256) begin : g_bad_param
    $error("fsw_bus_cycle: cycle counts must lie in 1..256");
  end

  typedef enum logic [2:0] {
    CY_IDLE = 3'b000,
    CY_SETUP = 3'b001,
    CY_PULSE = 3'b010,
    CY_HOLD = 3'b011,
    CY_SAMPLE = 3'b100
  } fsw_cyc_state_t;

  typedef struct packed {
    fsw_cyc_state_t st;
    logic [7:0] cnt;
    logic wr;
    fsw_pins_t pins;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic [DATA_W-1:0] s3;
  } fsw_cyc_reg_t;

  localparam fsw_cyc_reg_t CYC_RESET = '{st: CY_IDLE, cnt: 8'h00, wr: 1'b0,
    pins: PINS_IDLE, rdata: '0, done: 1'b0, s1: '0, s2: '0, s3: '0};

  fsw_cyc_reg_t q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.s1 = dq_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    case (q.st)
      CY_IDLE: begin
        if (start_i) begin
          // Chip select falls with output strobe still high.
          d.wr = req_i.wr;
          d.pins.addr = req_i.addr;
          d.pins.dq = req_i.data;
          d.pins.ce_n = 1'b0;
          d.pins.oe_n = 1'b1;
          d.pins.we_n = 1'b1;
          d.cnt = 8'(SETUP_CYC - 1);
          d.st = CY_SETUP;
        end
      end
      CY_SETUP: begin
        if (q.cnt == 8'h00) begin
          if (q.wr) begin
            d.pins.we_n = 1'b0;
            d.pins.dq_drv_n = 1'b0;
            d.cnt = 8'(STROBE_MIN_CYC - 1);
          end else begin
            d.pins.oe_n = 1'b0;
            d.cnt = 8'(RD_WAIT_CYC - 1);
          end
          d.st = CY_PULSE;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      CY_PULSE: begin
        if (q.cnt == 8'h00) begin
          if (q.wr) begin
            d.pins.we_n = 1'b1;
            d.cnt = 8'(HOLD_CYC - 1);
            d.st = CY_HOLD;
          end else begin
            d.st = CY_SAMPLE;
          end
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      CY_SAMPLE: begin
        // Read data is taken only once two synchroniser stages agree.
        if (q.s2 == q.s3) begin
          d.rdata = q.s3;
          d.pins = PINS_IDLE;
          d.pins.addr = q.pins.addr;
          d.done = 1'b1;
          d.st = CY_IDLE;
        end
      end
      CY_HOLD: begin
        if (q.cnt == 8'h00) begin
          d.pins.ce_n = 1'b1;
          d.pins.dq_drv_n = 1'b1;
          d.done = 1'b1;
          d.st = CY_IDLE;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      default: d = CYC_RESET;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= CYC_RESET;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign pins_o = q.pins;
  assign rdata_o = q.rdata;
  assign done_o = q.done;

endmodule // fsw_bus_cycle

// ===== verilog/fsw_host_ctrl.sv
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fsw_host_ctrl
  import fsw_pkg::*;
#(
  parameter logic [ADDR_W-1:0] UNLK_ADDR1 = 21'h000555,
  parameter logic [DATA_W-1:0] UNLK_DATA1 = 16'h00aa,
  parameter logic [ADDR_W-1:0] UNLK_ADDR2 = 21'h0002aa,
  parameter logic [DATA_W-1:0] UNLK_DATA2 = 16'h0055,
  parameter int PWRUP_CYC = 64,
  parameter int RST_PULSE_CYC = 16,
  parameter int RD_WAIT_CYC = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic ready_pin_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic reset_n_o,
  output logic vid_en_o,
  output logic write_protect_accel_pin_o,
  output logic accelerated_program_o
);

  // A one-cycle power-up hold could look exactly like the reset state.
  if (PWRUP_CYC < 2 || PWRUP_CYC > 65535 || RST_PULSE_CYC < 1 ||
      RST_PULSE_CYC > 65535) begin : g_bad_param
    $error("fsw_host_ctrl: power-up 2..65535, reset pulse 1..65535");
  end

  typedef enum logic [2:0] {
    M_PWRUP = 3'b000,
    M_IDLE = 3'b001,
    M_ISSUE = 3'b010,
    M_WAIT = 3'b011,
    M_RSTPULSE = 3'b100
  } fsw_main_state_t;

  typedef struct packed {
    fsw_main_state_t st;
    logic [15:0] cnt;
    fsw_op_t op;
    logic [2:0] step;
    logic [2:0] last;
    logic [5:0] ctrl;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [15:0] code;
    logic [DATA_W-1:0] rdata;
    logic secured;
    logic refused;
    logic pwr_done;
    logic rdy1;
    logic rdy2;
    logic rdy3;
    logic rdy;
  } fsw_main_reg_t;

  localparam fsw_main_reg_t MAIN_RESET = '{st: M_PWRUP, cnt: 16'h0000,
    op: OP_NONE, step: 3'h0, last: 3'h0, ctrl: CTRL_RESET, addr: '0,
    wdata: '0, code: 16'h0000, rdata: '0, secured: 1'b0, refused: 1'b0,
    pwr_done: 1'b0, rdy1: 1'b0, rdy2: 1'b0, rdy3: 1'b0, rdy: 1'b0};

  fsw_main_reg_t q, d;
  fsw_cyc_t cyc_req;
  fsw_pins_t pins;
  logic [DATA_W-1:0] cyc_rdata;
  logic cyc_done;
  logic cyc_start;
  logic wr_acc;
  logic cmd_ok;
  fsw_op_t new_op;

  // Every program or erase starts with the two unlock writes; erase repeats them before its second command word.
  function automatic fsw_cyc_t step_cycle(input fsw_op_t op,
                                          input logic [2:0] step,
                                          input logic [ADDR_W-1:0] addr,
                                          input logic [DATA_W-1:0] wdata,
                                          input logic [15:0] code);
    fsw_cyc_t c;
    logic [2:0] s;
    c = '{wr: 1'b1, addr: addr, data: wdata};
    s = (op == OP_ERASE && step > 3'h2) ? step - 3'h3 : step;
    case (op)
      OP_READ: c.wr = 1'b0;
      OP_PROT, OP_UNPROT: c.wr = 1'b1;
      default: begin
        if (s == 3'h0) begin
          c = '{wr: 1'b1, addr: UNLK_ADDR1, data: UNLK_DATA1};
        end else if (s == 3'h1) begin
          c = '{wr: 1'b1, addr: UNLK_ADDR2, data: UNLK_DATA2};
        end else if (step == 3'h2) begin
          c = '{wr: 1'b1, addr: UNLK_ADDR1, data: {8'h00, code[7:0]}};
        end else if (op == OP_ERASE) begin
          c = '{wr: 1'b1, addr: addr, data: {8'h00, code[15:8]}};
        end
      end
    endcase
    return c;
  endfunction

  assign wr_acc = psel_i && penable_i && pwrite_i && clk_en_i;
  assign new_op = fsw_op_t'(pwdata_i[3:0]);

  // Decides whether a command written by software may be started.
  always_comb begin
    cmd_ok = (q.st == M_IDLE);
    case (new_op)
      OP_READ, OP_ERASE, OP_CMD3:
        // Locked region must be left before the array is used.
        cmd_ok = cmd_ok && !(q.secured && q.ctrl[CTRL_REGION_LOCKED]);
      OP_PROG:
        cmd_ok = cmd_ok && !(q.secured && q.ctrl[CTRL_REGION_LOCKED]) &&
                 !(q.secured && q.ctrl[CTRL_ACCEL_REQ]);
      OP_ENTER, OP_EXIT, OP_HWRST: cmd_ok = cmd_ok;
      // Region lock needs the elevated reset level unless the secured region is mapped.
      OP_PROT: cmd_ok = cmd_ok && (q.ctrl[CTRL_VID_REQ] || q.secured);
      OP_UNPROT:
        cmd_ok = cmd_ok && q.ctrl[CTRL_VID_REQ] &&
                 q.ctrl[CTRL_ALL_PROT] && !q.secured;
      default: cmd_ok = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    cyc_start = 1'b0;
    d.rdy1 = ready_pin_i;
    d.rdy2 = q.rdy1;
    d.rdy3 = q.rdy2;
    if (q.rdy2 == q.rdy3) begin
      d.rdy = q.rdy3;
    end
    if (wr_acc) begin
      case (paddr_i)
        OFF_CTRL: d.ctrl = pwdata_i[5:0];
        OFF_ADDR: d.addr = pwdata_i[ADDR_W-1:0];
        OFF_WDATA: d.wdata = pwdata_i[DATA_W-1:0];
        OFF_CODE: d.code = pwdata_i[15:0];
        OFF_STATUS: begin
          if (pwdata_i[ST_REFUSED]) begin
            d.refused = 1'b0;
          end
        end
        OFF_CMD: begin
          if (cmd_ok) begin
            d.op = new_op;
            d.step = 3'h0;
            case (new_op)
              OP_PROG: d.last = 3'h3;
              OP_ERASE: d.last = 3'h5;
              OP_ENTER, OP_EXIT, OP_CMD3: d.last = 3'h2;
              default: d.last = 3'h0;
            endcase
            if (new_op == OP_HWRST) begin
              d.cnt = 16'(RST_PULSE_CYC - 1);
              d.st = M_RSTPULSE;
            end else begin
              d.st = M_ISSUE;
            end
          end else begin
            d.refused = 1'b1;
          end
        end
        default: d = d;
      endcase
    end
    case (q.st)
      M_PWRUP, M_RSTPULSE: begin
        // Strobes stay idle while the flash comes out of reset.
        if (q.cnt == 16'h0000) begin
          d.pwr_done = 1'b1;
          d.secured = 1'b0;
          d.st = M_IDLE;
        end else begin
          d.cnt = q.cnt - 16'h0001;
        end
      end
      M_IDLE: d.st = d.st;
      M_ISSUE: begin
        cyc_start = 1'b1;
        d.st = M_WAIT;
      end
      M_WAIT: begin
        if (cyc_done) begin
          if (q.op == OP_READ) begin
            d.rdata = cyc_rdata;
          end
          if (q.step == q.last) begin
            // Host tracks the boot-area mapping of the flash.
            if (q.op == OP_ENTER) begin
              d.secured = 1'b1;
            end else if (q.op == OP_EXIT) begin
              d.secured = 1'b0;
            end
            d.st = M_IDLE;
          end else begin
            d.step = q.step + 3'h1;
            d.st = M_ISSUE;
          end
        end
      end
      default: d = MAIN_RESET;
    endcase
    if (q.st == M_PWRUP && q.cnt == 16'h0000 && q == MAIN_RESET) begin
      d.cnt = 16'(PWRUP_CYC - 1);
      d.pwr_done = 1'b0;
      d.st = M_PWRUP;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= MAIN_RESET;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign cyc_req = step_cycle(q.op, q.step, q.addr, q.wdata, q.code);

  fsw_bus_cycle #(
    .SETUP_CYC(1),
    .HOLD_CYC(1),
    .RD_WAIT_CYC(RD_WAIT_CYC)
  ) u_cycle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_en_i(clk_en_i),
    .start_i(cyc_start),
    .req_i(cyc_req),
    .dq_i(dq_i),
    .pins_o(pins),
    .rdata_o(cyc_rdata),
    .done_o(cyc_done)
  );

  always_comb begin
    prdata_o = 32'h00000000;
    pslverr_o = 1'b0;
    case (paddr_i)
      OFF_CTRL: prdata_o = {26'h0000000, q.ctrl};
      OFF_ADDR: prdata_o = {11'h000, q.addr};
      OFF_WDATA: prdata_o = {16'h0000, q.wdata};
      OFF_CMD: prdata_o = {28'h0000000, q.op};
      OFF_STATUS: prdata_o = {25'h0000000, q.pwr_done,
        q.ctrl[CTRL_ACCEL_REQ] && !q.secured,
        q.ctrl[CTRL_VID_REQ] && q.pwr_done, q.rdy, q.refused,
        q.secured, q.st != M_IDLE};
      OFF_RDATA: prdata_o = {16'h0000, q.rdata};
      OFF_CODE: prdata_o = {16'h0000, q.code};
      default: pslverr_o = psel_i && penable_i;
    endcase
  end

  assign pready_o = clk_en_i;
  assign dq_o = pins.dq;
  assign dq_oe_n_o = pins.dq_drv_n;
  assign addr_o = pins.addr;
  assign ce_n_o = pins.ce_n;
  assign we_n_o = pins.we_n;
  assign oe_n_o = pins.oe_n;
  assign reset_n_o = (q.st != M_PWRUP) && (q.st != M_RSTPULSE);
  // Elevated level only once the flash is out of power-up.
  assign vid_en_o = q.ctrl[CTRL_VID_REQ] && q.pwr_done;
  // Pin comes from a reset flop, so it is never left floating.
  assign write_protect_accel_pin_o = q.ctrl[CTRL_WP_LEVEL];
  // Accelerate level is withheld while the secured region is mapped.
  assign accelerated_program_o = q.ctrl[CTRL_ACCEL_REQ] &&
                                 !q.secured;

endmodule // fsw_host_ctrl

// ===== sim/fsw_host_ctrl_asserts.sv
`timescale 1ns/1ps
module fsw_host_ctrl_chk
  import fsw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic dq_oe_n_o,
  input wire logic [ADDR_W-1:0] addr_o,
  input wire logic ce_n_o,
  input wire logic we_n_o,
  input wire logic oe_n_o,
  input wire logic reset_n_o,
  input wire logic write_protect_accel_pin_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_we_ce_oe: assert property (!we_n_o |-> !ce_n_o && oe_n_o)
    else $error("write strobe without select or with read strobe");
  a_we_min_len: assert property ($fell(we_n_o) |=> !we_n_o)
    else $error("write strobe shorter than two cycles");
  a_ce_setup: assert property ($fell(we_n_o) |-> !$past(ce_n_o))
    else $error("select not set up before write strobe");
  a_data_hold: assert property (!we_n_o && !$past(we_n_o)
    |-> $stable(addr_o) && $stable(dq_o))
    else $error("address or data moved during write strobe");
  a_rst_no_wr: assert property (!reset_n_o |-> we_n_o && ce_n_o)
    else $error("strobes active while flash held in reset");
  a_dq_driven: assert property (!we_n_o |-> !dq_oe_n_o)
    else $error("data bus not driven during write strobe");
  a_no_contend: assert property (!oe_n_o |-> dq_oe_n_o)
    else $error("host drives data bus while flash outputs");
  a_wp_follow: assert property (psel_i && penable_i && pwrite_i
    && clk_en_i && paddr_i == OFF_CTRL
    |=> {31'h00000000, write_protect_accel_pin_o} ==
        ($past(pwdata_i) & 32'h00000001))
    else $error("write-protect pin does not follow control write");
endmodule // fsw_host_ctrl_chk

bind fsw_host_ctrl fsw_host_ctrl_chk u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .clk_en_i(clk_en_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .dq_o(dq_o),
  .dq_oe_n_o(dq_oe_n_o),
  .addr_o(addr_o),
  .ce_n_o(ce_n_o),
  .we_n_o(we_n_o),
  .oe_n_o(oe_n_o),
  .reset_n_o(reset_n_o),
  .write_protect_accel_pin_o(write_protect_accel_pin_o)
);

// ===== sim/fsw_flash_model.sv
`timescale 1ns/1ps
module fsw_flash_model
  import fsw_pkg::*;
#(
  parameter bit FACTORY_LOCKED = 1'b0,
  parameter bit PROT_OUTER = 1'b0,
  parameter logic [ADDR_W-1:0] OUTER_END = 21'h002000,
  parameter logic [ADDR_W-1:0] SERIAL_BASE = 21'h000000
) (
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic reset_n_i,
  input wire logic vid_i,
  input wire logic wp_i,
  input wire logic accel_i,
  output logic [DATA_W-1:0] dq_o,
  output logic ready_o
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] smem [int];
  logic [DATA_W-1:0] last = 16'h0000;
  logic [1:0] st = 2'd0;
  logic armed = 1'b0;
  logic sec = 1'b0;
  realtime t_fall = 0.0;
  logic vcc_ok = 1'b0;
  logic outer_lock;
  logic region_lock;
  // Known test words stand in for the serial number at the region's base.
  initial begin
    for (int i = 0; i < 8; i++)
      smem[SERIAL_BASE + i] = 16'h5e00 + 16'(i);
  end
  function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
    if (sec && a < 21'h008000)
      return smem.exists(a) ? smem[a] : 16'hffff;
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  assign ready_o = 1'b1;
  // A released bus shows the inverse of the last word, never a fixed level.
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd(addr_i) : ~last;
  always @(posedge oe_n_i) last = rd(addr_i);
  always @(negedge we_n_i) t_fall = $realtime;
  // Supply counts as up once the first reset has been released.
  always @(posedge reset_n_i) vcc_ok = 1'b1;
  always @(negedge reset_n_i) begin
    sec = 1'b0;
    st = 2'd0;
    armed = 1'b0;
  end
  always @(posedge we_n_i) begin
    if (!ce_n_i && oe_n_i && reset_n_i
        && vcc_ok && $realtime - t_fall >= 5.0) begin
      if (armed) begin
        armed = 1'b0;
        // The secured region is not subject to boot sector protection.
        outer_lock = !sec && addr_i < OUTER_END &&
                     (!wp_i ||
                      (PROT_OUTER && !vid_i));
        region_lock = sec &&
                      (FACTORY_LOCKED || accel_i);
        if (!outer_lock && !region_lock) begin
          if (sec)
            smem[addr_i] = dq_i;
          else
            mem[addr_i] = dq_i;
        end
      end else if (st == 0 && addr_i == 21'h000555 &&
                   dq_i == 16'h00aa)
        st = 2'd1;
      else if (st == 1 && addr_i == 21'h0002aa && dq_i == 16'h0055)
        st = 2'd2;
      else if (st == 2 && addr_i == 21'h000555) begin
        st = 2'd0;
        armed = (dq_i[7:0] == 8'ha0);
        if (dq_i[7:0] == 8'h88)
          sec = 1'b1;
        if (dq_i[7:0] == 8'h90)
          sec = 1'b0;
      end else
        st = 2'd0;
    end
  end
endmodule // fsw_flash_model

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import fsw_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, dq_oe_n, ce_n, we_n, oe_n, reset_n;
  logic vid, wp, accel, rdy;
  logic [DATA_W-1:0] dq_o, mdq, dq;
  logic [ADDR_W-1:0] addr;
  int errors = 0;
  int num_checks = 0;
  assign dq = !dq_oe_n ? dq_o : mdq;
  always #2 clk_i = ~clk_i;
  fsw_host_ctrl #(.PWRUP_CYC(4), .RST_PULSE_CYC(2), .RD_WAIT_CYC(4)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .clk_en_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .dq_i(dq), .ready_pin_i(rdy), .dq_o(dq_o),
    .dq_oe_n_o(dq_oe_n), .addr_o(addr), .ce_n_o(ce_n), .we_n_o(we_n),
    .oe_n_o(oe_n), .reset_n_o(reset_n), .vid_en_o(vid),
    .write_protect_accel_pin_o(wp), .accelerated_program_o(accel));
  fsw_flash_model #(.PROT_OUTER(1'b1)) u_flash (.ce_n_i(ce_n),
    .we_n_i(we_n), .oe_n_i(oe_n),
    .addr_i(addr), .dq_i(dq), .reset_n_i(reset_n), .vid_i(vid),
    .wp_i(wp), .accel_i(accel), .dq_o(mdq), .ready_o(rdy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Registered pins change at the access edge; callers look once settled.
    @(negedge clk_i);
  endtask
  task automatic op(input logic [3:0] c, input logic [20:0] a,
                    input logic [15:0] d, input logic [7:0] code);
    apb(1'b1, OFF_ADDR, {11'h0, a});
    apb(1'b1, OFF_WDATA, {16'h0, d});
    apb(1'b1, OFF_CODE, {24'h0, code});
    apb(1'b1, OFF_CMD, {28'h0, c});
    rd = 32'h1;
    for (int i = 0; i < 300 && rd[ST_BUSY] !== 1'b0; i++)
      apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[ST_BUSY], 1'b0, "operation finished");
  endtask
  task automatic rdflash(input logic [20:0] a, input logic [15:0] exp);
    op(OP_READ, a, 16'h0, 8'h00);
    apb(1'b0, OFF_RDATA, 32'h0);
    chk({16'h0, rd[15:0]}, {16'h0, exp}, "flash word");
  endtask
  task automatic status_bit(input int b, input logic v);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[b], v, "status bit");
  endtask
  task automatic t_reset;
    apb(1'b1, OFF_CMD, 32'h1);
    chk({reset_n, ce_n, we_n, wp}, 4'b0110, "pins in hold");
    status_bit(ST_REFUSED, 1'b1);
    repeat (4) apb(1'b0, OFF_STATUS, 32'h0);
    apb(1'b1, OFF_STATUS, 32'h4);
    status_bit(ST_PWR_DONE, 1'b1);
    chk(rd[ST_REFUSED], 1'b0, "refusal cleared");
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1, "unmapped offset");
    op(OP_UNPROT, 21'h0, 16'h0, 8'h00);
    status_bit(ST_REFUSED, 1'b1);
    apb(1'b1, OFF_STATUS, 32'h4);
    op(OP_PROT, 21'h0, 16'h0, 8'h00);
    status_bit(ST_REFUSED, 1'b1);
    apb(1'b1, OFF_STATUS, 32'h4);
    $display("t_reset done");
  endtask
  task automatic t_wp;
    apb(1'b1, OFF_CTRL, 32'h0);
    op(OP_PROG, 21'h001fff, 16'h1111, 8'ha0);
    rdflash(21'h001fff, 16'hffff);
    op(OP_PROG, 21'h002000, 16'h0bcd, 8'ha0);
    rdflash(21'h002000, 16'h0bcd);
    apb(1'b1, OFF_CTRL, 32'h1);
    chk(wp, 1'b1, "write-protect pin");
    op(OP_PROG, 21'h000010, 16'h1234, 8'ha0);
    rdflash(21'h000010, 16'hffff);
    apb(1'b1, OFF_CTRL, 32'h3);
    chk(vid, 1'b1, "elevated reset request");
    op(OP_PROG, 21'h000010, 16'h1234, 8'ha0);
    rdflash(21'h000010, 16'h1234);
    op(OP_UNPROT, 21'h0, 16'h0, 8'h00);
    status_bit(ST_REFUSED, 1'b1);
    apb(1'b1, OFF_STATUS, 32'h4);
    op(OP_PROT, 21'h0, 16'h0, 8'h00);
    status_bit(ST_REFUSED, 1'b0);
    apb(1'b1, OFF_CTRL, 32'h2);
    op(OP_PROG, 21'h000011, 16'h2222, 8'ha0);
    rdflash(21'h000011, 16'hffff);
    apb(1'b1, OFF_CTRL, 32'h1);
    chk(vid, 1'b0, "elevated reset removed");
    op(OP_PROG, 21'h000012, 16'h3333, 8'ha0);
    rdflash(21'h000012, 16'hffff);
    $display("t_wp done");
  endtask
  task automatic t_sec;
    op(OP_ENTER, 21'h0, 16'h0, 8'h88);
    status_bit(ST_SECURED, 1'b1);
    rdflash(21'h000010, 16'hffff);
    rdflash(21'h000003, 16'h5e03);
    op(OP_PROG, 21'h000010, 16'h5a5a, 8'ha0);
    rdflash(21'h000010, 16'h5a5a);
    apb(1'b1, OFF_CTRL, 32'h5);
    chk(accel, 1'b0, "accel pin in region");
    op(OP_PROG, 21'h000010, 16'h0000, 8'ha0);
    status_bit(ST_REFUSED, 1'b1);
    apb(1'b1, OFF_STATUS, 32'h4);
    apb(1'b1, OFF_CTRL, 32'h1);
    op(OP_EXIT, 21'h0, 16'h0, 8'h90);
    status_bit(ST_SECURED, 1'b0);
    rdflash(21'h000010, 16'h1234);
    op(OP_ENTER, 21'h0, 16'h0, 8'h88);
    apb(1'b1, OFF_CTRL, 32'h11);
    op(OP_PROG, 21'h000010, 16'h0000, 8'ha0);
    status_bit(ST_REFUSED, 1'b1);
    apb(1'b1, OFF_STATUS, 32'h4);
    op(OP_HWRST, 21'h0, 16'h0, 8'h00);
    status_bit(ST_SECURED, 1'b0);
    rdflash(21'h000010, 16'h1234);
    $display("t_sec done");
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_wp();
    t_sec();
    end_of_test();
  end
  // The tests need about a thousand cycles; this leaves ample margin.
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule // tb_top
